// *** splb_ctrl.sv ***
// Serial print line buffer controller: start-up, size probe, DMA capture, printer drain, bit clocks
// Operation
// RULE_01: Send only when shifter empty and printer ready.
// RULE_02: Load byte with low pulse on hold load.
// RULE_03: No new load until shift-empty returns high.
// RULE_04: Printer flag low means ready, high waits.
// RULE_05: Bit clocks run at sixteen times baud.
// RULE_06: Receive and transmit rates selected independently.
// RULE_07: Nine rates from 110 to 19200 baud.
// RULE_08: Reset always restarts from the first step.
// RULE_09: Signature decides warm start or cold probe.
// RULE_10: No buffer RAM: blink error until reset.
// RULE_11: Probe accepts 4K up to 32K bytes.
// RULE_12: End pointer holds probed RAM size.
// RULE_13: Both pointers start at 8001H, 8000H reserved.
// RULE_14: Sample replay flag after init, low replays.
// RULE_15: DMA stores received byte at write pointer.
// RULE_16: One cycle per stored byte, no overhead.
// RULE_17: Pointers differ: bounds check, then transmit.
// RULE_18: Read pointer out of bounds flags error.
// RULE_19: Print length beyond RAM: steady error, stop.
// RULE_20: Work between DMA inputs well under budget.
// RULE_21: Character available raises DMA, cleared during it; the code pulses rx_available_clear in the cycle after the transfer.
// RULE_22: Write pointer increments after each DMA; the code stops it once it stands one past the end pointer.
// RULE_23: Replay switch makes reset reprint stored buffer.
// RULE_24: Equal pointers: send nothing, await next byte.
`timescale 1ns/1ps
`default_nettype none
module splb_ctrl
   import splb_pkg::*;
#(
   parameter int unsigned REF_CLK_HZ   = SPLB_REF_CLK_HZ,
   parameter int unsigned BLINK_CYCLES = SPLB_BLINK_CYCLES
)
(
   input  wire logic       ref_clk,
   input  wire logic       nrst,
   input  wire logic       rx_char_available,
   input  wire logic [7:0] rx_data,
   output logic            rx_available_clear,
   input  wire logic       tx_shift_empty,
   output logic            tx_hold_load_n,
   output logic [7:0]      tx_data,
   input  wire logic       printer_ready_flag,
   input  wire logic       replay_request_flag,
   input  wire logic [3:0] rx_rate_sel,
   input  wire logic [3:0] tx_rate_sel,
   output logic            rx_bit_clock,
   output logic            tx_bit_clock,
   input  wire logic [3:0] ram_fitted_blocks,
   output logic            error_led,
   output logic [16:0]     memory_end_pointer,
   output logic            halted
);

   splb_state_t   state;
   splb_mem_req_t mem_req;
   logic [7:0]    mem_rdata;

   logic [11:0]   sync_meta;
   logic [11:0]   sync_s;
   logic [7:0]    rx_data_s;
   logic          avail_d;
   logic          avail_s;
   logic          tx_empty_s;
   logic          printer_s;
   logic          replay_s;

   logic [16:0]   dma_write_pointer;
   logic [16:0]   printer_read_pointer;
   logic [16:0]   saved_write_pointer;
   logic [15:0]   start_signature_reg;
   logic          dma_pending;
   logic          dma_ok;
   logic          dma_go;
   logic [3:0]    probe_k;
   logic [16:0]   probe_addr;
   logic [31:0]   blink_cnt;
   logic [7:0]    load_cnt;
   logic [16:0]   rx_half_cnt;
   logic [16:0]   tx_half_cnt;

   splb_mem u_mem (
      .ref_clk       (ref_clk),
      .req           (mem_req),
      .fitted_blocks (ram_fitted_blocks),
      .rdata         (mem_rdata)
   );

   // Pins cross in through two flops; rx_data is held while available stands
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         sync_meta <= 12'h00f;
         sync_s    <= 12'h00f;
         avail_d   <= 1'b1;
      end else begin
         sync_meta <= {rx_data, replay_request_flag, printer_ready_flag, tx_shift_empty, rx_char_available};
         sync_s    <= sync_meta;
         avail_d   <= sync_s[0];
      end
   end

   assign avail_s    = sync_s[0];
   assign tx_empty_s = sync_s[1];
   assign printer_s  = sync_s[2];
   assign replay_s   = sync_s[3];
   assign rx_data_s  = sync_s[11:4];

   // DMA is locked out during start-up and while the drain owns the memory port
   assign dma_ok = state inside {ST_IDLE, ST_BOUNDS, ST_TXCHK, ST_PRINTER_READY_CHECK, ST_DATA, ST_LOAD, ST_ACK};
   assign dma_go = dma_pending && dma_ok;

   // A new edge in the service cycle wins over the clear
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         dma_pending <= 1'b0;
      end else if (avail_s && !avail_d) begin
         dma_pending <= 1'b1; // see RULE_21
      end else if (dma_go) begin
         dma_pending <= 1'b0;
      end
   end

   // Clear pulse retires the request in the cycle after the one-cycle transfer
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rx_available_clear <= 1'b0;
      end else begin
         rx_available_clear <= dma_go; // see RULE_21
      end
   end

   assign probe_addr = SPLB_RAM_BASE + 17'({probe_k, 12'h000}) + SPLB_BLOCK_LAST;

   // Single memory port: DMA first, then probe or drain
   always_comb begin
      mem_req = '0;
      if (dma_go) begin
         mem_req.we    = dma_write_pointer < memory_end_pointer; // see RULE_16
         mem_req.addr  = dma_write_pointer[15:0]; // see RULE_15
         mem_req.wdata = rx_data_s;
      end else begin
         case (state)
            ST_PWR: begin
               mem_req.we    = 1'b1;
               mem_req.addr  = probe_addr[15:0];
               mem_req.wdata = SPLB_PROBE_BYTE;
            end
            ST_PRD:  mem_req.addr = probe_addr[15:0];
            ST_READ: mem_req.addr = printer_read_pointer[15:0];
            default: mem_req = '0;
         endcase
      end
   end

   // Signature survives button reset; unknown at power-up forces a cold start
   always_ff @(posedge ref_clk) begin
      if (state == ST_COLD) begin
         start_signature_reg <= SPLB_WARM_SIG; // see RULE_09
      end
   end

   // Probe result is kept over button reset, like the buffer itself
   always_ff @(posedge ref_clk) begin
      if (state == ST_PCHK) begin
         if (mem_rdata == SPLB_PROBE_BYTE && probe_k == SPLB_MAX_BLOCKS - SPLB_MIN_BLOCKS) begin
            memory_end_pointer <= SPLB_RAM_BASE + 17'({SPLB_MAX_BLOCKS, 12'h000}); // see RULE_11
         end else if (mem_rdata != SPLB_PROBE_BYTE) begin
            memory_end_pointer <= SPLB_RAM_BASE + 17'({probe_k, 12'h000}); // see RULE_12
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (dma_go && dma_write_pointer < memory_end_pointer) begin
         saved_write_pointer <= dma_write_pointer + 17'h00001;
      end
   end

   // Main sequence
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         state <= ST_START; // see RULE_08
      end else begin
         case (state)
            ST_START: begin
               if (start_signature_reg == SPLB_WARM_SIG) begin
                  state <= ST_INIT; // see RULE_09
               end else begin
                  state <= ST_COLD;
               end
            end
            ST_COLD:   state <= ST_PWR;
            ST_PWR:    state <= ST_PRD;
            ST_PRD:    state <= ST_PCHK;
            ST_PCHK: begin
               if (mem_rdata == SPLB_PROBE_BYTE) begin
                  if (probe_k == SPLB_MAX_BLOCKS - SPLB_MIN_BLOCKS) begin
                     state <= ST_INIT; // see RULE_11
                  end else begin
                     state <= ST_PWR;
                  end
               end else if (probe_k == 4'h0) begin
                  state <= ST_BLINK; // see RULE_10
               end else begin
                  state <= ST_INIT;
               end
            end
            ST_BLINK:  state <= ST_BLINK;
            ST_INIT:   state <= ST_REPLAY;
            ST_REPLAY: state <= ST_IDLE; // see RULE_14
            ST_IDLE: begin
               if (printer_read_pointer != dma_write_pointer) begin // see RULE_24
                  state <= ST_BOUNDS; // see RULE_17
               end
            end
            ST_BOUNDS: begin
               if (printer_read_pointer < SPLB_BUF_FIRST || printer_read_pointer >= memory_end_pointer) begin
                  state <= ST_HALT; // see RULE_18 RULE_19
               end else begin
                  state <= ST_TXCHK;
               end
            end
            ST_TXCHK: begin
               if (tx_empty_s) begin
                  state <= ST_PRINTER_READY_CHECK; // see RULE_03
               end
            end
            ST_PRINTER_READY_CHECK: begin
               if (!tx_empty_s) begin
                  state <= ST_TXCHK;
               end else if (!printer_s) begin
                  state <= ST_READ; // see RULE_01 RULE_04
               end
            end
            ST_READ:   state <= ST_DATA;
            ST_DATA:   state <= ST_LOAD;
            ST_LOAD: begin
               if (load_cnt == 8'(SPLB_TX_LOAD_CYCLES - 1)) begin
                  state <= ST_ACK;
               end
            end
            ST_ACK: begin
               if (!tx_empty_s) begin
                  state <= ST_IDLE; // see RULE_02
               end
            end
            ST_HALT:   state <= ST_HALT;
            default:   state <= ST_START;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         probe_k <= 4'h0;
      end else if (state == ST_COLD) begin
         probe_k <= 4'h0;
      end else if (state == ST_PCHK && mem_rdata == SPLB_PROBE_BYTE) begin
         probe_k <= probe_k + 4'h1;
      end
   end

   // Write pointer: init, replay restore, step per byte, once past the end on overrun
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         dma_write_pointer <= SPLB_BUF_FIRST;
      end else if (state == ST_INIT) begin
         dma_write_pointer <= SPLB_BUF_FIRST; // see RULE_13
      end else if (state == ST_REPLAY && !replay_s && saved_write_pointer > SPLB_BUF_FIRST &&
                   saved_write_pointer <= memory_end_pointer) begin
         dma_write_pointer <= saved_write_pointer; // see RULE_23
      end else if (dma_go && dma_write_pointer <= memory_end_pointer) begin
         dma_write_pointer <= dma_write_pointer + 17'h00001; // see RULE_22 RULE_19
      end
   end

   // Drain loop is a handful of cycles, far inside the gap between two characters
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         printer_read_pointer <= SPLB_BUF_FIRST;
      end else if (state == ST_INIT) begin
         printer_read_pointer <= SPLB_BUF_FIRST; // see RULE_13
      end else if (state == ST_ACK && !tx_empty_s) begin
         printer_read_pointer <= printer_read_pointer + 17'h00001; // see RULE_20
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         tx_data <= 8'h00;
      end else if (state == ST_DATA) begin
         tx_data <= mem_rdata;
      end
   end

   // Data and load fall together; the transmitter latches on the rising edge
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         tx_hold_load_n <= 1'b1;
         load_cnt       <= 8'h00;
      end else if (state == ST_DATA) begin
         tx_hold_load_n <= 1'b0; // see RULE_02
         load_cnt       <= 8'h00;
      end else if (state == ST_LOAD) begin
         if (load_cnt == 8'(SPLB_TX_LOAD_CYCLES - 1)) begin
            tx_hold_load_n <= 1'b1;
         end
         load_cnt <= load_cnt + 8'h01;
      end else begin
         tx_hold_load_n <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         error_led <= 1'b0;
         blink_cnt <= 32'h00000000;
      end else if (state == ST_BLINK) begin
         if (blink_cnt >= BLINK_CYCLES - 1) begin
            blink_cnt <= 32'h00000000;
            error_led <= !error_led; // see RULE_10
         end else begin
            blink_cnt <= blink_cnt + 32'h00000001;
         end
      end else begin
         blink_cnt <= 32'h00000000;
         error_led <= (state == ST_HALT); // see RULE_19
      end
   end

   assign halted = (state == ST_HALT);

   // Two dividers off one clock; rates may differ
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rx_half_cnt  <= 17'h00000;
         rx_bit_clock <= 1'b0;
      end else if (rx_half_cnt >= splb_half(rx_rate_sel, REF_CLK_HZ) - 17'h00001) begin
         rx_half_cnt  <= 17'h00000;
         rx_bit_clock <= !rx_bit_clock; // see RULE_05
      end else begin
         rx_half_cnt  <= rx_half_cnt + 17'h00001; // see RULE_06
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         tx_half_cnt  <= 17'h00000;
         tx_bit_clock <= 1'b0;
      end else if (tx_half_cnt >= splb_half(tx_rate_sel, REF_CLK_HZ) - 17'h00001) begin
         tx_half_cnt  <= 17'h00000;
         tx_bit_clock <= !tx_bit_clock; // see RULE_07
      end else begin
         tx_half_cnt  <= tx_half_cnt + 17'h00001; // see RULE_06
      end
   end

endmodule : splb_ctrl
`default_nettype wire

// *** splb_ctrl_asserts.sv ***
// Port-level assertions for the line buffer controller, bound to every instance
`timescale 1ns/1ps
`default_nettype none
module splb_ctrl_asserts
   import splb_pkg::*;
#(
   parameter int unsigned REF_CLK_HZ   = SPLB_REF_CLK_HZ,
   parameter int unsigned BLINK_CYCLES = SPLB_BLINK_CYCLES
)
(
   input wire logic        ref_clk,
   input wire logic        nrst,
   input wire logic        rx_char_available,
   input wire logic        rx_available_clear,
   input wire logic        tx_shift_empty,
   input wire logic        tx_hold_load_n,
   input wire logic [7:0]  tx_data,
   input wire logic        printer_ready_flag,
   input wire logic        error_led,
   input wire logic [16:0] memory_end_pointer,
   input wire logic        halted
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   logic        led_last;
   logic        led_seen;
   int unsigned led_hold;
   int unsigned load_low;

   // Cycles since the error light last changed, and since the load pulse began
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         led_last <= 1'b0;
         led_seen <= 1'b0;
         led_hold <= 0;
         load_low <= 0;
      end else begin
         led_last <= error_led;
         load_low <= tx_hold_load_n ? 0 : load_low + 1;
         led_hold <= (error_led != led_last) ? 0 : led_hold + 1;
         if (error_led != led_last) begin
            led_seen <= 1'b1;
         end
      end
   end

   // Two sync flops plus the check pipeline put the pin sample 5 edges back
   property p_load_gate;
      $fell(tx_hold_load_n) |-> $past(tx_shift_empty, 5) && !$past(printer_ready_flag, 5);
   endproperty
   a_load_gate: assert property (p_load_gate) else $error("load without idle shifter or ready printer");
   property p_load_width;
      tx_hold_load_n ? load_low inside {0, SPLB_TX_LOAD_CYCLES} : load_low < SPLB_TX_LOAD_CYCLES;
   endproperty
   a_load_width: assert property (p_load_width) else $error("load pulse width wrong");
   property p_data_hold;
      !tx_hold_load_n && !$past(tx_hold_load_n) |-> $stable(tx_data);
   endproperty
   a_data_hold: assert property (p_data_hold) else $error("tx data moved during load");
   property p_shift_gap;
      $rose(tx_shift_empty) |-> tx_hold_load_n [*5];
   endproperty
   a_shift_gap: assert property (p_shift_gap) else $error("load too soon after shifter freed");
   property p_clear_once;
      rx_available_clear |=> !rx_available_clear;
   endproperty
   a_clear_once: assert property (p_clear_once) else $error("clear pulse longer than one cycle");
   property p_clear_cause;
      $rose(rx_char_available) |-> ##[2:8] rx_available_clear;
   endproperty
   a_clear_cause: assert property (p_clear_cause) else $error("received byte not serviced in time");
   property p_blink;
      $changed(error_led) && !halted && led_seen |-> led_hold == BLINK_CYCLES - 1;
   endproperty
   a_blink: assert property (p_blink) else $error("error light blink period wrong");
   property p_halt_led;
      halted |=> error_led;
   endproperty
   a_halt_led: assert property (p_halt_led) else $error("halt without steady error light");
   property p_end_range;
      rx_available_clear |-> memory_end_pointer inside {[17'h09000:17'h10000]} && memory_end_pointer[11:0] == 12'h000;
   endproperty
   a_end_range: assert property (p_end_range) else $error("end pointer outside probe range");

   c_load: cover property ($fell(tx_hold_load_n));
   c_clear: cover property (rx_available_clear);
   c_blink: cover property ($changed(error_led) && led_seen);
endmodule : splb_ctrl_asserts

bind splb_ctrl splb_ctrl_asserts #(.REF_CLK_HZ(REF_CLK_HZ), .BLINK_CYCLES(BLINK_CYCLES)) u_chk (
   .ref_clk(ref_clk), .nrst(nrst), .rx_char_available(rx_char_available),
   .rx_available_clear(rx_available_clear), .tx_shift_empty(tx_shift_empty),
   .tx_hold_load_n(tx_hold_load_n), .tx_data(tx_data), .printer_ready_flag(printer_ready_flag),
   .error_led(error_led), .memory_end_pointer(memory_end_pointer), .halted(halted));
`default_nettype wire

// *** splb_mem.sv ***
// Buffer memory of up to 32K bytes with fitted-size decode and registered read
`timescale 1ns/1ps
`default_nettype none
module splb_mem
   import splb_pkg::*;
(
   input  wire logic          ref_clk,
   input  wire splb_mem_req_t req,
   input  wire logic [3:0]    fitted_blocks,
   output logic [7:0]         rdata
);

   logic [7:0] store [0:32767];
   logic       present;

   // Unfitted space floats high, so the probe sees no echo there
   assign present = req.addr[15] && ({1'b0, req.addr[14:12]} < fitted_blocks);

   // No reset: contents must survive a button reset for replay
   always_ff @(posedge ref_clk) begin
      if (req.we && present) begin
         store[req.addr[14:0]] <= req.wdata;
      end
   end

   always_ff @(posedge ref_clk) begin
      rdata <= present ? store[req.addr[14:0]] : 8'hff;
   end

endmodule : splb_mem
`default_nettype wire

// *** splb_pkg.sv ***
// Shared constants, rate table and types for the serial print line buffer
package splb_pkg;

   // System clock
   localparam int unsigned SPLB_REF_CLK_HZ     = 100_000_000;
   localparam int unsigned SPLB_REF_CLK_MHZ    = SPLB_REF_CLK_HZ / 1_000_000;

   // Start signature and probe pattern
   localparam logic [15:0] SPLB_WARM_SIG       = 16'haaaa;
   localparam logic [7:0]  SPLB_PROBE_BYTE     = 8'haa;

   // Buffer memory map, 17-bit pointers so one-past-the-top of 32K is representable
   localparam logic [16:0] SPLB_RAM_BASE       = 17'h08000;
   localparam logic [16:0] SPLB_BUF_FIRST      = 17'h08001;
   localparam logic [16:0] SPLB_BLOCK_LAST     = 17'h00fff;
   localparam int unsigned SPLB_BLOCK_SHIFT    = 12;
   localparam logic [3:0]  SPLB_MIN_BLOCKS     = 4'h1;
   localparam logic [3:0]  SPLB_MAX_BLOCKS     = 4'h8;

   // Bit clock generation
   localparam int unsigned SPLB_OVERSAMPLE     = 16;
   localparam logic [3:0]  SPLB_RATE_110       = 4'h0;
   localparam logic [3:0]  SPLB_RATE_150       = 4'h1;
   localparam logic [3:0]  SPLB_RATE_300       = 4'h2;
   localparam logic [3:0]  SPLB_RATE_600       = 4'h3;
   localparam logic [3:0]  SPLB_RATE_1200      = 4'h4;
   localparam logic [3:0]  SPLB_RATE_2400      = 4'h5;
   localparam logic [3:0]  SPLB_RATE_4800      = 4'h6;
   localparam logic [3:0]  SPLB_RATE_9600      = 4'h7;
   localparam logic [3:0]  SPLB_RATE_19200     = 4'h8;

   // Timing
   localparam int unsigned SPLB_BLINK_MS       = 250;
   localparam int unsigned SPLB_BLINK_CYCLES   = SPLB_BLINK_MS * (SPLB_REF_CLK_HZ / 1000);
   localparam int unsigned SPLB_TX_LOAD_NS     = 100;
   localparam int unsigned SPLB_TX_LOAD_CYCLES = (SPLB_TX_LOAD_NS * SPLB_REF_CLK_MHZ + 999) / 1000;

   typedef struct packed {
      logic        we;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } splb_mem_req_t;

   typedef enum logic [16:0] {
      ST_START  = 17'h00001,
      ST_COLD   = 17'h00002,
      ST_PWR    = 17'h00004,
      ST_PRD    = 17'h00008,
      ST_PCHK   = 17'h00010,
      ST_BLINK  = 17'h00020,
      ST_INIT   = 17'h00040,
      ST_REPLAY = 17'h00080,
      ST_IDLE   = 17'h00100,
      ST_BOUNDS = 17'h00200,
      ST_TXCHK  = 17'h00400,
      ST_PRINTER_READY_CHECK = 17'h00800,
      ST_READ   = 17'h01000,
      ST_DATA   = 17'h02000,
      ST_LOAD   = 17'h04000,
      ST_ACK    = 17'h08000,
      ST_HALT   = 17'h10000
   } splb_state_t;

   function automatic int unsigned splb_baud(input logic [3:0] sel);
      case (sel)
         SPLB_RATE_110:   splb_baud = 110;
         SPLB_RATE_150:   splb_baud = 150;
         SPLB_RATE_300:   splb_baud = 300;
         SPLB_RATE_600:   splb_baud = 600;
         SPLB_RATE_1200:  splb_baud = 1200;
         SPLB_RATE_2400:  splb_baud = 2400;
         SPLB_RATE_4800:  splb_baud = 4800;
         SPLB_RATE_9600:  splb_baud = 9600;
         SPLB_RATE_19200: splb_baud = 19200;
         default:         splb_baud = 9600;
      endcase
   endfunction : splb_baud

   // Half period of the 16x clock in ref_clk cycles, never below one
   function automatic logic [16:0] splb_half(input logic [3:0] sel, input int unsigned hz);
      int unsigned h;
      h = hz / (2 * SPLB_OVERSAMPLE * splb_baud(sel));
      if (h == 0) begin
         h = 1;
      end
      splb_half = h[16:0];
   endfunction : splb_half

endpackage : splb_pkg

// *** splb_uart_model.sv ***
// Transmitter shifter and printer handshake model on the far side
`timescale 1ns/1ps
`default_nettype none
module splb_uart_model #(
   parameter int unsigned SHIFT_CYCLES = 20,
   parameter int unsigned BUSY_CYCLES  = 45
)
(
   input  wire logic ref_clk,
   input  wire logic tx_hold_load_n,
   input  wire logic slow,
   output logic      tx_shift_empty,
   output logic      printer_ready_flag
);
   int unsigned shift_cnt = 0;
   int unsigned busy_cnt  = 0;

   initial begin
      tx_shift_empty = 1'b1;
      printer_ready_flag = 1'b0;
   end

   // Slow printer goes busy on each character, longer than the shifter
   always @(posedge ref_clk) begin
      if (!tx_hold_load_n) begin
         tx_shift_empty <= #1 1'b0;
         shift_cnt <= SHIFT_CYCLES;
         busy_cnt <= slow ? BUSY_CYCLES : 0;
         printer_ready_flag <= #1 slow;
      end else begin
         if (shift_cnt != 0) begin
            shift_cnt <= shift_cnt - 1;
         end else begin
            tx_shift_empty <= #1 1'b1;
         end
         if (busy_cnt != 0) begin
            busy_cnt <= busy_cnt - 1;
         end else begin
            printer_ready_flag <= #1 1'b0;
         end
      end
   end
endmodule : splb_uart_model
`default_nettype wire

// *** tb_serial_print_line_buffer.sv ***
// Self-checking bench: probe, bit clocks, capture, drain, replay
`timescale 1ns/1ps
`default_nettype none
module tb_serial_print_line_buffer;
   import splb_pkg::*;
   // Slow reference keeps the bit clock dividers short
   localparam int unsigned HZ = 1_843_200;
   logic        ref_clk  = 1'b0;
   logic        nrst     = 1'b0;
   logic        avail    = 1'b0;
   logic [7:0]  rx_data  = 8'h00;
   logic        replay_n = 1'b1;
   logic [3:0]  rx_sel   = 4'h8;
   logic [3:0]  tx_sel   = 4'h7;
   logic [3:0]  blocks   = 4'h2;
   logic        slow     = 1'b0;
   logic        last_load = 1'b1;
   wire logic   rx_clr, tx_empty, load_n, prn, rx_bclk, tx_bclk, led, halted, b_led, b_halt;
   wire logic [7:0]  tx_data;
   wire logic [16:0] end_ptr;
   int          err_count = 0;
   int          cmp_count = 0;
   int          seed      = 72996;
   int          n;
   logic        v;
   logic [7:0]  expq[$];
   logic [7:0]  stored[$];
   int          bauds[9] = '{110, 150, 300, 600, 1200, 2400, 4800, 9600, 19200};

   always #5 ref_clk = ~ref_clk;

   splb_ctrl #(.REF_CLK_HZ(HZ), .BLINK_CYCLES(8)) u_dut (
      .ref_clk(ref_clk), .nrst(nrst), .rx_char_available(avail), .rx_data(rx_data),
      .rx_available_clear(rx_clr), .tx_shift_empty(tx_empty), .tx_hold_load_n(load_n),
      .tx_data(tx_data), .printer_ready_flag(prn), .replay_request_flag(replay_n),
      .rx_rate_sel(rx_sel), .tx_rate_sel(tx_sel), .rx_bit_clock(rx_bclk), .tx_bit_clock(tx_bclk),
      .ram_fitted_blocks(blocks), .error_led(led), .memory_end_pointer(end_ptr), .halted(halted));
   // No buffer memory fitted at all
   splb_ctrl #(.REF_CLK_HZ(HZ), .BLINK_CYCLES(8)) u_dut_bare (
      .ref_clk(ref_clk), .nrst(nrst), .rx_char_available(1'b0), .rx_data(rx_data),
      .rx_available_clear(), .tx_shift_empty(tx_empty), .tx_hold_load_n(),
      .tx_data(), .printer_ready_flag(prn), .replay_request_flag(replay_n),
      .rx_rate_sel(rx_sel), .tx_rate_sel(tx_sel), .rx_bit_clock(), .tx_bit_clock(),
      .ram_fitted_blocks(4'h0), .error_led(b_led), .memory_end_pointer(), .halted(b_halt));
   splb_uart_model u_model (.ref_clk(ref_clk), .tx_hold_load_n(load_n), .slow(slow),
      .tx_shift_empty(tx_empty), .printer_ready_flag(prn));

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t %s got %0h exp %0h", $time, what, got, exp);
      end
   endtask : check

   task automatic tally_and_finish;
      $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : tally_and_finish

   task automatic tick(input int k);
      repeat (k) @(posedge ref_clk);
      #1;
   endtask : tick

   task automatic do_reset(input int k);
      nrst = 1'b0;
      tick(k);
      nrst = 1'b1;
   endtask : do_reset

   task automatic half_period(input bit sel, output int h);
      logic s;
      int   k;
      k = 0;
      s = sel ? tx_bclk : rx_bclk;
      while ((sel ? tx_bclk : rx_bclk) === s && k < 2000) begin
         tick(1);
         k++;
      end
      s = sel ? tx_bclk : rx_bclk;
      h = 0;
      while ((sel ? tx_bclk : rx_bclk) === s && h < 2000) begin
         tick(1);
         h++;
      end
   endtask : half_period

   task automatic send_byte(input logic [7:0] b);
      int k;
      k = 0;
      expq.push_back(b);
      stored.push_back(b);
      rx_data = b;
      avail = 1'b1;
      while (rx_clr !== 1'b1 && k < 40) begin
         tick(1);
         k++;
      end
      check(k < 40, 1'b1, "dma clear");
      avail = 1'b0;
      rx_data = ~b;
      tick(3 + $unsigned($random(seed)) % 8);
   endtask : send_byte

   task automatic wait_drain;
      int k;
      k = 0;
      while (expq.size() != 0 && k < 20000) begin
         tick(1);
         k++;
      end
      check(expq.size(), 0, "buffer drained");
      tick(100);
   endtask : wait_drain

   // Each falling load edge consumes the oldest expected byte
   always @(posedge ref_clk) begin
      #2;
      if (nrst === 1'b1 && last_load === 1'b1 && load_n === 1'b0) begin
         if (expq.size() == 0) check(1'b1, 1'b0, "unexpected byte");
         else check(tx_data, expq.pop_front(), "printed byte");
      end
      last_load = load_n;
   end

   initial begin
      #600us;
      err_count++;
      $display("[FAIL] %0t watchdog expired", $time);
      tally_and_finish();
   end

   initial begin
      do_reset(6);
      tick(80);
      check(end_ptr, 17'h0a000, "probed end");
      check(led, 1'b0, "no error");
      n = 0;
      v = b_led;
      repeat (64) begin
         tick(1);
         if (b_led !== v) n++;
         v = b_led;
      end
      check(n, 8, "blink toggles");
      check(b_halt, 1'b0, "blink not halt");
      for (int r = 0; r < 9; r++) begin
         rx_sel = r[3:0];
         tx_sel = 4'(8 - r);
         do_reset(2);
         half_period(1'b0, n);
         check(n, HZ / (32 * bauds[r]), "rx half period");
         half_period(1'b1, n);
         check(n, HZ / (32 * bauds[8 - r]), "tx half period");
      end
      check(end_ptr, 17'h0a000, "warm keeps end");
      rx_sel = SPLB_RATE_19200;
      tx_sel = SPLB_RATE_9600;
      do_reset(2);
      tick(40);
      for (int i = 0; i < 24; i++) begin
         slow = 1'($random(seed));
         send_byte(8'($random(seed)));
      end
      wait_drain();
      replay_n = 1'b0;
      do_reset(2);
      foreach (stored[i]) expq.push_back(stored[i]);
      tick(40);
      replay_n = 1'b1;
      wait_drain();
      send_byte(8'($random(seed)));
      send_byte(8'($random(seed)));
      wait_drain();
      do_reset(2);
      tick(200);
      send_byte(8'($random(seed)));
      wait_drain();
      check(halted, 1'b0, "no halt");
      tally_and_finish();
   end
endmodule : tb_serial_print_line_buffer
`default_nettype wire
